// ---- logic/acc_regs.vh ----
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define ACC_ADDR_STATUS_CONTROL 8'h00
`define ACC_ADDR_SYSTEM_OPTIONS 8'h01
`define ACC_ADDR_POWER_CONTROL 8'h02
`define ACC_ADDR_MODE_STATUS 8'h03

// ----------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------
`define ACC_SC_MODULE_ENABLE 7
`define ACC_SC_REF_SELECT 6
`define ACC_SC_EVENT_FLAG 5
`define ACC_SC_IRQ_ENABLE 4
`define ACC_SC_RESULT_BIT 3
`define ACC_SC_PIN_DRIVE 2
`define ACC_SC_EDGE_HI 1
`define ACC_SC_EDGE_LO 0

// ----------------------------------------------------------------
// Option, power and mode status field positions
// ----------------------------------------------------------------
`define ACC_OPT_CAPTURE_ROUTE 0
`define ACC_PWR_BANDGAP_BUFFER 0
`define ACC_MS_WAIT 0
`define ACC_MS_LIGHT_STOP 1
`define ACC_MS_ROUTED 2
`define ACC_MS_PIN_DRIVEN 3
`define ACC_MS_REF_UNBUFFERED 4

// ----------------------------------------------------------------
// Edge select encodings
// ----------------------------------------------------------------
`define ACC_EDGE_FALL_A 2'h0
`define ACC_EDGE_RISE 2'h1
`define ACC_EDGE_FALL_B 2'h2
`define ACC_EDGE_BOTH 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACC_SC_RESET 8'h00
`define ACC_OPT_RESET 1'h0
`define ACC_PWR_RESET 1'h0
`define ACC_EDGE_RESET 2'h0

`endif

// ---- logic/acc_edge_detect.v ----
`timescale 1ns/1ps
`include "acc_regs.vh"

module acc_edge_detect (
  input wire clk,
  input wire rst,
  input wire async_in,
  input wire enable,
  input wire [1:0] edge_sel,
  output reg level_q,
  output reg event_q
);

  // ----------------------------------------------------------------
  // Synchroniser and edge history
  // ----------------------------------------------------------------
  reg meta_q;
  reg sync_q;
  reg prev_q;
  reg armed_q;
  reg rise;
  reg fall;
  reg hit;

  // Two stages; only sync_q reads meta_q
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      armed_q <= enable;
    end
  end

  // Edge select decode; armed_q hides the edge seen at enable
  always @* begin
    rise = sync_q & ~prev_q;
    fall = ~sync_q & prev_q;
    case (edge_sel)
      `ACC_EDGE_FALL_A: hit = fall;
      `ACC_EDGE_RISE: hit = rise;
      `ACC_EDGE_FALL_B: hit = fall;
      default: hit = rise | fall;
    endcase
  end

  // Registered level and one-cycle event
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      level_q <= enable & sync_q;
      event_q <= enable & armed_q & hit;
    end
  end

endmodule // acc_edge_detect

// ---- logic/acc_analog_compare_unit.v ----
`timescale 1ns/1ps
`include "acc_regs.vh"

module acc_analog_compare_unit (
  input wire CLOCK,
  input wire RESET,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire CMP_RAW,
  input wire TIMER_PIN_IN,
  input wire WAIT_MODE,
  input wire LIGHT_STOP,
  input wire DEEP_STOP,
  output reg CMP_POWER_ON,
  output reg REF_BANDGAP_SEL,
  output reg BANDGAP_BUFFER_ON,
  output reg RESULT_PIN_OUT,
  output reg RESULT_PIN_OE,
  output reg TIMER_CAPTURE_IN,
  output reg TIMER_PIN_CONNECT,
  output reg IRQ,
  output reg WAKEUP
);

  // ----------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------
  reg compare_module_enable_q;
  reg compare_module_enable_d;
  reg reference_source_select_q;
  reg reference_source_select_d;
  reg compare_event_flag_q;
  reg compare_event_flag_d;
  reg compare_irq_enable_q;
  reg compare_irq_enable_d;
  reg compare_pin_drive_enable_q;
  reg compare_pin_drive_enable_d;
  reg [1:0] compare_edge_select_q;
  reg [1:0] compare_edge_select_d;
  reg compare_to_capture_route_q;
  reg compare_to_capture_route_d;
  reg bandgap_buffer_enable_q;
  reg bandgap_buffer_enable_d;

  // ----------------------------------------------------------------
  // Decoded strobes and derived values
  // ----------------------------------------------------------------
  reg wr_sc;
  reg wr_opt;
  reg wr_pwr;
  reg [7:0] read_mux;
  wire compare_level;
  wire compare_event;
  wire timer_pin_level;
  wire compare_result_bit;
  wire [7:0] sc_view;
  wire [7:0] mode_view;
  wire irq_d;
  wire low_power;

  // ----------------------------------------------------------------
  // Comparator synchroniser and edge detector
  // ----------------------------------------------------------------

  // Detector sees the enable only; wait and light stop never gate it, deep stop clears the enable
  acc_edge_detect u_cmp_edge (
    .clk(CLOCK),
    .rst(RESET),
    .async_in(CMP_RAW),
    .enable(compare_module_enable_q),
    .edge_sel(compare_edge_select_q),
    .level_q(compare_level),
    .event_q(compare_event)
  );

  // Timer pin is foreign to this clock, so it is synchronised too
  acc_edge_detect u_pin_sync (
    .clk(CLOCK),
    .rst(RESET),
    .async_in(TIMER_PIN_IN),
    .enable(1'b1),
    .edge_sel(`ACC_EDGE_BOTH),
    .level_q(timer_pin_level),
    .event_q()
  );

  // Level already cleared one cycle late; gate for an exact read
  assign compare_result_bit = compare_module_enable_q & compare_level;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Write strobes per register; unmapped writes fall through
  always @* begin
    wr_sc = 1'b0;
    wr_opt = 1'b0;
    wr_pwr = 1'b0;
    if (WR && ADDR == `ACC_ADDR_STATUS_CONTROL) begin
      wr_sc = 1'b1;
    end else if (WR && ADDR == `ACC_ADDR_SYSTEM_OPTIONS) begin
      wr_opt = 1'b1;
    end else if (WR && ADDR == `ACC_ADDR_POWER_CONTROL) begin
      wr_pwr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control register next state
  // ----------------------------------------------------------------

  // Deep stop acts as a synchronous reset of every field
  always @* begin
    compare_module_enable_d = compare_module_enable_q;
    reference_source_select_d = reference_source_select_q;
    compare_irq_enable_d = compare_irq_enable_q;
    compare_pin_drive_enable_d = compare_pin_drive_enable_q;
    compare_edge_select_d = compare_edge_select_q;
    compare_to_capture_route_d = compare_to_capture_route_q;
    bandgap_buffer_enable_d = bandgap_buffer_enable_q;
    if (DEEP_STOP) begin
      compare_module_enable_d = 1'b0;
      reference_source_select_d = 1'b0;
      compare_irq_enable_d = 1'b0;
      compare_pin_drive_enable_d = 1'b0;
      compare_edge_select_d = `ACC_EDGE_RESET;
      compare_to_capture_route_d = `ACC_OPT_RESET;
      bandgap_buffer_enable_d = `ACC_PWR_RESET;
    end else begin
      if (wr_sc) begin
        compare_module_enable_d = WDATA[`ACC_SC_MODULE_ENABLE];
        reference_source_select_d = WDATA[`ACC_SC_REF_SELECT];
        compare_irq_enable_d = WDATA[`ACC_SC_IRQ_ENABLE];
        compare_pin_drive_enable_d = WDATA[`ACC_SC_PIN_DRIVE];
        compare_edge_select_d = WDATA[`ACC_SC_EDGE_HI:`ACC_SC_EDGE_LO];
      end
      if (wr_opt) begin
        compare_to_capture_route_d = WDATA[`ACC_OPT_CAPTURE_ROUTE];
      end
      if (wr_pwr) begin
        bandgap_buffer_enable_d = WDATA[`ACC_PWR_BANDGAP_BUFFER];
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flag
  // ----------------------------------------------------------------

  // Write-one clears; a same-cycle event wins so none is lost
  always @* begin
    compare_event_flag_d = compare_event_flag_q;
    if (wr_sc && WDATA[`ACC_SC_EVENT_FLAG]) begin
      compare_event_flag_d = 1'b0;
    end
    if (compare_event) begin
      compare_event_flag_d = 1'b1;
    end
    if (DEEP_STOP) begin
      compare_event_flag_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------

  // Asynchronous reset covers reset exit from light stop
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      compare_module_enable_q <= 1'b0;
      reference_source_select_q <= 1'b0;
      compare_event_flag_q <= 1'b0;
      compare_irq_enable_q <= 1'b0;
      compare_pin_drive_enable_q <= 1'b0;
      compare_edge_select_q <= `ACC_EDGE_RESET;
      compare_to_capture_route_q <= `ACC_OPT_RESET;
      bandgap_buffer_enable_q <= `ACC_PWR_RESET;
    end else begin
      compare_module_enable_q <= compare_module_enable_d;
      reference_source_select_q <= reference_source_select_d;
      compare_event_flag_q <= compare_event_flag_d;
      compare_irq_enable_q <= compare_irq_enable_d;
      compare_pin_drive_enable_q <= compare_pin_drive_enable_d;
      compare_edge_select_q <= compare_edge_select_d;
      compare_to_capture_route_q <= compare_to_capture_route_d;
      bandgap_buffer_enable_q <= bandgap_buffer_enable_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake-up
  // ----------------------------------------------------------------

  // Built from next state so IRQ lines up with the flag register
  assign irq_d = compare_event_flag_d & compare_irq_enable_d;
  assign low_power = WAIT_MODE | LIGHT_STOP;

  // Wake is the request qualified by a low-power mode
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
      WAKEUP <= 1'b0;
    end else begin
      IRQ <= irq_d;
      WAKEUP <= irq_d & low_power;
    end
  end

  // ----------------------------------------------------------------
  // Analog core controls, result pin and capture routing
  // ----------------------------------------------------------------

  // Only deep stop touches these, so wait and light stop keep them live
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      CMP_POWER_ON <= 1'b0;
      REF_BANDGAP_SEL <= 1'b0;
      BANDGAP_BUFFER_ON <= 1'b0;
      RESULT_PIN_OUT <= 1'b0;
      RESULT_PIN_OE <= 1'b0;
      TIMER_CAPTURE_IN <= 1'b0;
      TIMER_PIN_CONNECT <= 1'b1;
    end else begin
      CMP_POWER_ON <= compare_module_enable_d & ~DEEP_STOP;
      REF_BANDGAP_SEL <= reference_source_select_d;
      BANDGAP_BUFFER_ON <= bandgap_buffer_enable_d;
      RESULT_PIN_OUT <= compare_pin_drive_enable_q & compare_result_bit;
      RESULT_PIN_OE <= compare_pin_drive_enable_d & compare_module_enable_d;
      if (compare_to_capture_route_q) begin
        TIMER_CAPTURE_IN <= compare_result_bit;
      end else begin
        TIMER_CAPTURE_IN <= timer_pin_level;
      end
      TIMER_PIN_CONNECT <= ~compare_to_capture_route_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  assign sc_view = {compare_module_enable_q, reference_source_select_q,
                    compare_event_flag_q, compare_irq_enable_q,
                    compare_result_bit, compare_pin_drive_enable_q,
                    compare_edge_select_q};

  // Unbuffered flag warns that the bandgap was chosen without its buffer
  assign mode_view = {3'h0,
                      reference_source_select_q & ~bandgap_buffer_enable_q,
                      compare_pin_drive_enable_q & compare_module_enable_q,
                      compare_to_capture_route_q,
                      LIGHT_STOP,
                      WAIT_MODE};

  // Unmapped offsets read as zero
  always @* begin
    if (ADDR == `ACC_ADDR_STATUS_CONTROL) begin
      read_mux = sc_view;
    end else if (ADDR == `ACC_ADDR_SYSTEM_OPTIONS) begin
      read_mux = {7'h00, compare_to_capture_route_q};
    end else if (ADDR == `ACC_ADDR_POWER_CONTROL) begin
      read_mux = {7'h00, bandgap_buffer_enable_q};
    end else if (ADDR == `ACC_ADDR_MODE_STATUS) begin
      read_mux = mode_view;
    end else begin
      read_mux = 8'h00;
    end
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= read_mux;
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule // acc_analog_compare_unit

// ---- verification/acc_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module acc_props (
  input wire CLOCK,
  input wire RESET,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire CMP_RAW,
  input wire TIMER_PIN_IN,
  input wire WAIT_MODE,
  input wire LIGHT_STOP,
  input wire DEEP_STOP,
  input wire CMP_POWER_ON,
  input wire REF_BANDGAP_SEL,
  input wire BANDGAP_BUFFER_ON,
  input wire RESULT_PIN_OUT,
  input wire RESULT_PIN_OE,
  input wire TIMER_CAPTURE_IN,
  input wire TIMER_PIN_CONNECT,
  input wire IRQ,
  input wire WAKEUP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Wake needs a pending request and a low-power mode
  wake_gate_a:
    assert property (WAKEUP |-> IRQ && $past(WAIT_MODE || LIGHT_STOP))
    else $error("wake without request or mode");
  // Request only drops on a write or deep stop
  irq_hold_a:
    assert property ($fell(IRQ) |-> $past(WR) || $past(DEEP_STOP))
    else $error("request dropped by itself");
  // Pin connection moves only by option write or deep stop
  route_chg_a:
    assert property ($changed(TIMER_PIN_CONNECT) |->
      $past(WR) || $past(DEEP_STOP))
    else $error("pin connection changed by itself");
  // Option 0x01 bit 0 cuts the timer pin off
  route_val_a:
    assert property (WR && ADDR == 8'h01 && !DEEP_STOP |=>
      TIMER_PIN_CONNECT == !$past(WDATA[0]))
    else $error("route option not applied");
  // Module enable powers the analog core
  core_power_a:
    assert property (WR && ADDR == 8'h00 && !DEEP_STOP |=>
      CMP_POWER_ON == $past(WDATA[7]))
    else $error("core power does not follow enable");
  // Deep stop returns core power, request, wake, pin connection and pin enable to reset values
  deep_clear_a:
    assert property (DEEP_STOP |=> !CMP_POWER_ON && !IRQ && !WAKEUP
      && TIMER_PIN_CONNECT && !RESULT_PIN_OE)
    else $error("deep stop left state behind");
  // Result bit reads zero while disabled
  res_zero_a:
    assert property (RD && ADDR == 8'h00 && !CMP_POWER_ON |=> !RDATA[3])
    else $error("result bit set while disabled");
  // Pin is only driven by an enabled module
  pin_oe_a:
    assert property (RESULT_PIN_OE |-> CMP_POWER_ON)
    else $error("pin driven while disabled");
  // Unrouted capture follows the pin after the synchroniser
  cap_path_a:
    assert property ((TIMER_PIN_CONNECT && !DEEP_STOP
      && $stable(TIMER_PIN_IN) && $stable(TIMER_PIN_CONNECT))[*6]
      |-> TIMER_CAPTURE_IN == TIMER_PIN_IN)
    else $error("capture input does not follow pin");
  irq_c: cover property ($rose(IRQ));
  wake_c: cover property (WAKEUP);
  routed_c: cover property (!TIMER_PIN_CONNECT);
endmodule // acc_props

bind acc_analog_compare_unit acc_props i_acc_props (.*);

// ---- verification/acc_far_side.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Analog core and timer pin stand-in
// ----------------------------------------
module acc_far_side (
  input wire power_on,
  input wire level_cmd,
  input wire pin_cmd,
  output logic cmp_raw,
  output logic timer_pin
);
  logic last_q = 1'b0;
  // Unpowered core shows no valid level, so invert the last one
  always @(power_on or level_cmd)
    if (power_on) last_q = level_cmd;
  assign cmp_raw = power_on ? level_cmd : ~last_q;
  assign timer_pin = pin_cmd;
endmodule // acc_far_side

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_top;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic lvl = 0;
  logic pcmd = 0;
  logic wait_m = 0;
  logic light = 0;
  logic deep = 0;
  wire [7:0] rdata;
  wire raw, tpin, pwr, ref_sel, bg_on, pout, poe, cap, conn, irq, wake;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  acc_analog_compare_unit i_acc_analog_compare_unit (
    .CLOCK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CMP_RAW(raw), .TIMER_PIN_IN(tpin),
    .WAIT_MODE(wait_m), .LIGHT_STOP(light), .DEEP_STOP(deep),
    .CMP_POWER_ON(pwr), .REF_BANDGAP_SEL(ref_sel),
    .BANDGAP_BUFFER_ON(bg_on), .RESULT_PIN_OUT(pout),
    .RESULT_PIN_OE(poe), .TIMER_CAPTURE_IN(cap),
    .TIMER_PIN_CONNECT(conn), .IRQ(irq), .WAKEUP(wake));
  acc_far_side i_acc_far_side (.power_on(pwr), .level_cmd(lvl),
    .pin_cmd(pcmd), .cmp_raw(raw), .timer_pin(tpin));
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // Bus cycles; #1 lets the edge's updates land first
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string what, input logic [7:0] a,
    input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  // Comparator level change, long enough for sync and flag
  task automatic setl(input logic v);
    @(posedge clk);
    lvl <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    wreg(8'h7F, 8'hFF);
    for (int a = 0; a < 4; a++) rchk("reg", a[7:0], 8'h00);
    rchk("unmapped", 8'h7F, 8'h00);
    chk("connect", 8'h01, {7'h00, conn});
  endtask
  task automatic t_edges();
    logic [7:0] m;
    logic f;
    for (int i = 0; i < 4; i++) begin
      m = i[7:0];
      setl(1'b0);
      wreg(8'h00, 8'h90 | m);
      repeat (8) @(posedge clk);
      wreg(8'h00, 8'hB0 | m);
      setl(1'b1);
      f = (m == 8'h01 || m == 8'h03);
      rchk("rise", 8'h00, 8'h98 | m | {2'h0, f, 5'h00});
      chk("irq", {7'h00, f}, {7'h00, irq});
      wreg(8'h00, 8'h90 | m);
      rchk("hold", 8'h00, 8'h98 | m | {2'h0, f, 5'h00});
      wreg(8'h00, 8'hB0 | m);
      setl(1'b0);
      f = (m != 8'h01);
      rchk("fall", 8'h00, 8'h90 | m | {2'h0, f, 5'h00});
    end
  endtask
  task automatic t_route();
    wreg(8'h01, 8'h01);
    chk("cut", 8'h00, {7'h00, conn});
    @(posedge clk);
    pcmd <= 1'b1;
    wreg(8'h00, 8'h84);
    setl(1'b1);
    chk("cap hi", 8'h01, {7'h00, cap});
    chk("pin", 8'h03, {6'h00, pout, poe});
    setl(1'b0);
    chk("cap lo", 8'h00, {7'h00, cap});
    wreg(8'h01, 8'h00);
    repeat (6) @(posedge clk);
    #1 chk("cap pin", 8'h03, {6'h00, cap, conn});
  endtask
  task automatic t_modes();
    @(posedge clk);
    light <= 1'b1;
    wreg(8'h00, 8'h95);
    repeat (8) @(posedge clk);
    wreg(8'h00, 8'hB5);
    setl(1'b1);
    chk("stop wake", 8'h03, {6'h00, wake, pout});
    chk("stop pin", 8'h01, {7'h00, poe});
    @(posedge clk);
    light <= 1'b0;
    wait_m <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("wait wake", 8'h01, {7'h00, wake});
    rchk("mode", 8'h03, 8'h09);
    @(posedge clk);
    deep <= 1'b1;
    wait_m <= 1'b0;
    @(posedge clk);
    deep <= 1'b0;
    rchk("deep sc", 8'h00, 8'h00);
    chk("deep out", 8'h01, {6'h00, pwr, conn});
    // Software leaves the core off in wait; no wake from a level change
    @(posedge clk);
    wait_m <= 1'b1;
    setl(1'b0);
    chk("wait off", 8'h00, {6'h00, pwr, wake});
    rchk("wait mode", 8'h03, 8'h01);
    @(posedge clk);
    wait_m <= 1'b0;
  endtask
  task automatic t_ref();
    wreg(8'h02, 8'h01);
    wreg(8'h00, 8'h40);
    chk("ref", 8'h03, {6'h00, ref_sel, bg_on});
    rchk("mode ok", 8'h03, 8'h00);
    wreg(8'h02, 8'h00);
    rchk("mode bad", 8'h03, 8'h10);
    wreg(8'h00, 8'hD4);
    wreg(8'h01, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) rchk("rst", a[7:0], 8'h00);
    chk("rst out", 8'h01, {6'h00, ref_sel, conn});
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_edges();
    t_route();
    t_modes();
    t_ref();
    close_out();
  end
endmodule // tb_top
